// *** rtl/ptxeq_defs.svh ***
// Constants for the per-lane transmit equalization controller
`ifndef PTXEQ_DEFS_SVH
`define PTXEQ_DEFS_SVH

// Control input encodings
`define PTXEQ_CTRL_IDLE 2'h0
`define PTXEQ_CTRL_PRESET 2'h1
`define PTXEQ_CTRL_COEFF 2'h2
`define PTXEQ_CTRL_QUERY 2'h3

// Link rate codes; equalization acts at these rates and above
`define PTXEQ_RATE_GEN3 2'h2

// Presets
`define PTXEQ_PRESET_DEFAULT 4'h4
`define PTXEQ_PRESET_MAX 4'ha

// Static driver descriptors
`define PTXEQ_FULL_SWING 6'h18
`define PTXEQ_LOW_FREQ 6'h08

// Preset table: {pre-cursor[11:6], post-cursor[5:0]} at the full swing above
`define PTXEQ_P0 12'h006
`define PTXEQ_P1 12'h004
`define PTXEQ_P2 12'h005
`define PTXEQ_P3 12'h003
`define PTXEQ_P4 12'h000
`define PTXEQ_P5 12'h080
`define PTXEQ_P6 12'h0c0
`define PTXEQ_P7 12'h0c5
`define PTXEQ_P8 12'h0c4
`define PTXEQ_P9 12'h100
`define PTXEQ_P10 12'h008

// Register byte offsets
`define PTXEQ_REG_CTRL 4'h0
`define PTXEQ_REG_STATUS 4'h4
`define PTXEQ_REG_COEFF 4'h8

// Register fields and reset values
`define PTXEQ_CTRL_EN_BIT 0
`define PTXEQ_CTRL_EN_RST 1'b1

`endif

// *** rtl/ptxeq_pkg.sv ***
// Types for the per-lane transmit equalization controller
package ptxeq_pkg;

	// Controller states, in debug code order
	typedef enum logic [2:0] {
		st_idle,
		st_preset,
		st_coeff,
		state_remap,
		state_query,
		st_done
	} ptxeq_state_t;

	// Transmit coefficient as carried on the coefficient output
	typedef struct packed {
		logic [5:0] pre;
		logic [5:0] main;
		logic [5:0] post;
	} ptxeq_coeff_t;

endpackage : ptxeq_pkg

// *** rtl/ptxeq_ctrl.sv ***
// Per-lane transmit equalization controller with Avalon-MM register slave
// Behaviour
// - Control 00 idle, 01 preset, 10 custom coefficient, 11 query.
// - Preset mode applies the preset code given on the preset input.
// - Preset 0100b is the default equalization until changed.
// - Presets 0000b..1010b map to fixed cursor pairs; others are reserved.
// - Coefficient mode applies the custom coefficient from the coefficient input.
// - Custom coefficient arrives over three cycles: pre, main, then post.
// - A constant six-bit full swing value is driven out.
// - A constant six-bit low frequency value is driven out.
// - Current coefficient output: pre 17:12, main 11:6, post 5:0.
// - Completion is a one-cycle pulse per finished operation.
// - Three-bit debug state: idle, preset, coeff, remap, query, done.
// - Functions work per lane and only at Gen3 and Gen4 rates.
`timescale 1ns/1ps
`default_nettype none
`include "ptxeq_defs.svh"

module ptxeq_ctrl
	import ptxeq_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Equalization request from the controller
	input wire logic [1:0] txeq_ctrl,
	input wire logic [3:0] txeq_preset,
	input wire logic [5:0] txeq_coeff,
	input wire logic [1:0] link_rate,
	// Equalization results
	output ptxeq_coeff_t txeq_new_coeff,
	output logic txeq_done,
	output logic [2:0] dbg_txeq_state,
	output logic [5:0] tx_full_swing_value,
	output logic [5:0] tx_low_freq_value,
	// Avalon-MM slave
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest
);

	// Preset code to coefficient; main takes what the side cursors leave
	function automatic ptxeq_coeff_t map_preset(input logic [3:0] code);
		logic [11:0] pair;
		ptxeq_coeff_t c;
		pair = `PTXEQ_P4;
		unique case (code)
			4'h0: pair = `PTXEQ_P0;
			4'h1: pair = `PTXEQ_P1;
			4'h2: pair = `PTXEQ_P2;
			4'h3: pair = `PTXEQ_P3;
			4'h4: pair = `PTXEQ_P4;
			4'h5: pair = `PTXEQ_P5;
			4'h6: pair = `PTXEQ_P6;
			4'h7: pair = `PTXEQ_P7;
			4'h8: pair = `PTXEQ_P8;
			4'h9: pair = `PTXEQ_P9;
			4'ha: pair = `PTXEQ_P10;
			default: pair = `PTXEQ_P4;
		endcase
		c.pre = pair[11:6];
		c.post = pair[5:0];
		c.main = 6'(`PTXEQ_FULL_SWING - pair[11:6] - pair[5:0]);
		return c;
	endfunction : map_preset

	// Reserved codes above the last preset
	function automatic logic preset_ok(input logic [3:0] code);
		return code <= `PTXEQ_PRESET_MAX;
	endfunction : preset_ok

	ptxeq_state_t state_r;
	ptxeq_state_t state_nxt;
	ptxeq_coeff_t coeff_r;
	logic [5:0] pre_r;
	logic [5:0] main_r;
	logic step_r;
	logic [3:0] preset_r;
	logic done_r;
	logic eq_en_r;
	logic wait_r;
	logic [31:0] rdata_r;
	logic [5:0] fs_r;
	logic [5:0] lf_r;
	logic rate_ok;
	logic bus_req;
	logic bus_commit;

	// Equalization only at Gen3/Gen4 and while software enables it
	assign rate_ok = (link_rate >= `PTXEQ_RATE_GEN3) && eq_en_r;

	// Next state
	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			st_idle: begin
				if (rate_ok) begin
					unique case (txeq_ctrl)
						`PTXEQ_CTRL_PRESET: state_nxt = st_preset;
						`PTXEQ_CTRL_COEFF: state_nxt = st_coeff;
						`PTXEQ_CTRL_QUERY: state_nxt = state_query;
						default: state_nxt = st_idle;
					endcase
				end
			end
			st_preset: state_nxt = state_remap;
			st_coeff: begin
				if (step_r) begin
					state_nxt = st_done;
				end
			end
			state_remap: state_nxt = st_done;
			state_query: state_nxt = st_done;
			st_done: begin
				// Hold done until the controller drops its request
				if (txeq_ctrl == `PTXEQ_CTRL_IDLE) begin
					state_nxt = st_idle;
				end
			end
			default: state_nxt = st_idle;
		endcase
	end

	// State register
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			state_r <= st_idle;
		end else begin
			state_r <= state_nxt;
		end
	end

	// Preset latch; reserved codes leave the last good preset in place
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			preset_r <= `PTXEQ_PRESET_DEFAULT;
		end else if (state_r == st_preset && preset_ok(txeq_preset)) begin
			preset_r <= txeq_preset;
		end
	end

	// Three-beat custom coefficient capture: pre, main, then post
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			pre_r <= 6'h00;
			main_r <= 6'h00;
			step_r <= 1'b0;
		end else if (state_r == st_idle) begin
			pre_r <= txeq_coeff;
			step_r <= 1'b0;
		end else if (state_r == st_coeff && !step_r) begin
			main_r <= txeq_coeff;
			step_r <= 1'b1;
		end
	end

	// Applied coefficient; the custom one lands whole on the post beat
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			coeff_r <= map_preset(`PTXEQ_PRESET_DEFAULT);
		end else if (state_r == state_remap) begin
			coeff_r <= map_preset(preset_r);
		end else if (state_r == st_coeff && step_r) begin
			coeff_r <= '{pre: pre_r, main: main_r, post: txeq_coeff};
		end
	end

	// One-cycle completion on entry to done
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			done_r <= 1'b0;
		end else begin
			done_r <= (state_nxt == st_done) && (state_r != st_done);
		end
	end

	// Static driver descriptors, held in flops so outputs stay registered
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			fs_r <= `PTXEQ_FULL_SWING;
			lf_r <= `PTXEQ_LOW_FREQ;
		end else begin
			fs_r <= `PTXEQ_FULL_SWING;
			lf_r <= `PTXEQ_LOW_FREQ;
		end
	end

	// Bus slave: one wait cycle, then answer; idle waitrequest stays high
	assign bus_req = avs_read || avs_write;
	assign bus_commit = bus_req && !wait_r;

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			wait_r <= 1'b1;
		end else begin
			wait_r <= !(bus_req && wait_r);
		end
	end

	// Read data, captured in the cycle waitrequest drops
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			rdata_r <= 32'h0000_0000;
		end else if (bus_req && wait_r && avs_read) begin
			unique case (avs_address)
				`PTXEQ_REG_CTRL: rdata_r <= {31'h0000_0000, eq_en_r};
				`PTXEQ_REG_STATUS: rdata_r <= {24'h00_0000, preset_r, 1'b0, state_r};
				`PTXEQ_REG_COEFF: rdata_r <= {14'h0000, coeff_r};
				default: rdata_r <= 32'h0000_0000;
			endcase
		end
	end

	// Enable write; a disable takes effect at the next idle, not mid-operation
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			eq_en_r <= `PTXEQ_CTRL_EN_RST;
		end else if (bus_commit && avs_write && avs_address == `PTXEQ_REG_CTRL
			&& avs_byteenable[0]) begin
			eq_en_r <= avs_writedata[`PTXEQ_CTRL_EN_BIT];
		end
	end

	// Outputs
	assign txeq_new_coeff = coeff_r;
	assign txeq_done = done_r;
	assign dbg_txeq_state = state_r;
	assign tx_full_swing_value = fs_r;
	assign tx_low_freq_value = lf_r;
	assign avs_readdata = rdata_r;
	assign avs_waitrequest = wait_r;

	// Checks
	a_done_single: assert property (@(posedge clk_sys) disable iff (rst)
		txeq_done |=> !txeq_done)
		else $error("completion pulse longer than one cycle");

	a_preset_path: assert property (@(posedge clk_sys) disable iff (rst)
		state_r == st_preset |=> state_r == state_remap ##1 state_r == st_done ##0 txeq_done)
		else $error("preset did not pass remap into done");

	a_coeff_beats: assert property (@(posedge clk_sys) disable iff (rst)
		(state_r == st_idle && rate_ok && txeq_ctrl == `PTXEQ_CTRL_COEFF)
		|=> state_r == st_coeff [*2] ##1 (state_r == st_done && txeq_done))
		else $error("custom coefficient not taken in three cycles");

	a_coeff_value: assert property (@(posedge clk_sys) disable iff (rst)
		(state_r == st_coeff && step_r)
		|=> txeq_new_coeff == {$past(pre_r), $past(main_r), $past(txeq_coeff)})
		else $error("custom coefficient applied wrongly");

	a_preset_map: assert property (@(posedge clk_sys) disable iff (rst)
		(state_r == st_preset && !preset_ok(txeq_preset)) |=> $stable(preset_r))
		else $error("reserved preset changed the setting");

	a_query_keep: assert property (@(posedge clk_sys) disable iff (rst)
		state_r == state_query |=> $stable(txeq_new_coeff) && txeq_done)
		else $error("query altered coefficient or missed done");

	a_rate_gate: assert property (@(posedge clk_sys) disable iff (rst)
		(state_r == st_idle && link_rate < `PTXEQ_RATE_GEN3) |=> state_r == st_idle)
		else $error("equalization started below Gen3");

	a_static_fs: assert property (@(posedge clk_sys) disable iff (rst)
		tx_full_swing_value == `PTXEQ_FULL_SWING && tx_low_freq_value == `PTXEQ_LOW_FREQ)
		else $error("driver descriptors not constant");

	a_main_sum: assert property (@(posedge clk_sys) disable iff (rst)
		state_r == state_remap |=> txeq_new_coeff.pre + txeq_new_coeff.main
		+ txeq_new_coeff.post == 8'(`PTXEQ_FULL_SWING))
		else $error("preset cursors do not sum to full swing");

	a_debug_done: assert property (@(posedge clk_sys) disable iff (rst)
		txeq_done |-> dbg_txeq_state == 3'h5)
		else $error("debug state not done at completion");

	// The applied setting may only move when an operation completes
	a_coeff_hold: assert property (@(posedge clk_sys) disable iff (rst)
		!$stable(txeq_new_coeff) |-> txeq_done)
		else $error("coefficient changed outside a completion");

	a_done_wait: assert property (@(posedge clk_sys) disable iff (rst)
		(state_r == st_done && txeq_ctrl != `PTXEQ_CTRL_IDLE) |=> state_r == st_done)
		else $error("left done before the request was dropped");

	a_query_entry: assert property (@(posedge clk_sys) disable iff (rst)
		(state_r == st_idle && rate_ok && txeq_ctrl == `PTXEQ_CTRL_QUERY)
		|=> state_r == state_query)
		else $error("query request not decoded");

	// Software disable must hold the lane in idle
	a_en_gate: assert property (@(posedge clk_sys) disable iff (rst)
		(state_r == st_idle && !eq_en_r) |=> state_r == st_idle)
		else $error("equalization started while disabled");

	// Bus answers in one cycle, never a second low cycle
	a_bus_wait: assert property (@(posedge clk_sys) disable iff (rst)
		!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low for more than one cycle");

endmodule : ptxeq_ctrl

`default_nettype wire

// *** testbench/ptxeq_mac_model.sv ***
// Far-side link controller model issuing equalization requests
`timescale 1ns/1ps
`default_nettype none

module ptxeq_mac_model (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Request lines toward the lane
	output logic [1:0] txeq_ctrl,
	output logic [3:0] txeq_preset,
	output logic [5:0] txeq_coeff,
	// Completion from the lane
	input wire logic txeq_done
);
	// Request lines idle until a request is asked for
	initial begin
		txeq_ctrl = 2'h0;
		txeq_preset = 4'h0;
		txeq_coeff = 6'h00;
	end

	// One request: pre, main, post beats, then idle once done is seen or after ten cycles
	task automatic req(input logic [1:0] c, input logic [3:0] p, input logic [17:0] cf,
		output bit got);
		got = 1'b0;
		@(posedge clk_sys);
		txeq_ctrl <= c;
		txeq_preset <= p;
		txeq_coeff <= cf[17:12];
		for (int i = 0; i < 10 && !got; i++) begin
			@(posedge clk_sys);
			if (i == 0) txeq_coeff <= cf[11:6];
			if (i == 1) txeq_coeff <= cf[5:0];
			// Beats over: keep the lines moving so stale data cannot pass
			if (i > 1) txeq_coeff <= ~txeq_coeff;
			// Done is launched on the edge, so look at it mid-cycle
			@(negedge clk_sys);
			got = (txeq_done === 1'b1);
		end
		// Release only just after a rising edge
		@(posedge clk_sys);
		txeq_ctrl <= 2'h0;
		// Idle held long enough for the lane to settle before the next one
		repeat (2) @(posedge clk_sys);
	endtask : req
endmodule : ptxeq_mac_model

`default_nettype wire

// *** testbench/tb.sv ***
// Self-checking bench for the transmit equalization controller
`timescale 1ns/1ps
`default_nettype none

module tb;
	import ptxeq_pkg::*;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic [1:0] txeq_ctrl;
	logic [3:0] txeq_preset;
	logic [5:0] txeq_coeff, fs, lf;
	logic [1:0] link_rate = 2'h3;
	ptxeq_coeff_t new_c;
	logic done;
	logic [2:0] st;
	logic [3:0] avs_address = 4'h0;
	logic [3:0] avs_be = 4'hf;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic avs_waitrequest;
	logic [31:0] avs_writedata = 32'h0000_0000;
	logic [31:0] avs_readdata, q;
	logic [17:0] exp_c = 18'h0_0600;
	logic [3:0] act = 4'h4;
	int err_total = 0;
	int n_compared = 0;
	bit got;
	int pre_tab[11] = '{0, 0, 0, 0, 0, 2, 3, 3, 3, 4, 0};
	int post_tab[11] = '{6, 4, 5, 3, 0, 0, 0, 5, 4, 0, 8};

	ptxeq_ctrl i_ptxeq_ctrl (.clk_sys(clk_sys), .rst(rst), .txeq_ctrl(txeq_ctrl),
		.txeq_preset(txeq_preset), .txeq_coeff(txeq_coeff), .link_rate(link_rate),
		.txeq_new_coeff(new_c), .txeq_done(done), .dbg_txeq_state(st),
		.tx_full_swing_value(fs), .tx_low_freq_value(lf), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_be), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

	ptxeq_mac_model i_ptxeq_mac_model (.clk_sys(clk_sys), .rst(rst), .txeq_ctrl(txeq_ctrl),
		.txeq_preset(txeq_preset), .txeq_coeff(txeq_coeff), .txeq_done(done));

	// 40 MHz system clock
	initial begin
		forever #12.5 clk_sys = ~clk_sys;
	end

	task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
		n_compared++;
		if (g !== e) begin
			err_total++;
			$display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, g, e);
		end
	endtask : chk

	task automatic final_report();
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : final_report

	// Bus access held until waitrequest is sampled low
	task automatic av(input bit wr, input logic [3:0] a, input logic [31:0] d);
		int n;
		logic w;
		n = 0;
		w = 1'b1;
		@(posedge clk_sys);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		// Outputs move on the edge; take them mid-cycle, act on the next edge
		while (w !== 1'b0 && n < 20) begin
			@(negedge clk_sys);
			w = avs_waitrequest;
			q = avs_readdata;
			@(posedge clk_sys);
			n++;
		end
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		if (w !== 1'b0) begin
			chk(0, 1, "bus timeout");
			final_report();
		end
	endtask : av

	// A missing completion is a hang, so the run ends there
	task automatic rq(input logic [1:0] c, input logic [3:0] p, input logic [17:0] cf, input bit e);
		i_ptxeq_mac_model.req(c, p, cf, got);
		chk(got, e, "done pulse");
		if (e && !got) final_report();
	endtask : rq

	// Results judged in the cycle the one-cycle done stands
	always @(negedge clk_sys) begin
		if (done === 1'b1) begin
			chk(new_c, exp_c, "coeff at done");
			chk(st, 3'd5, "state at done");
		end
	end

	initial begin
		void'($urandom(40));
		repeat (3) @(posedge clk_sys);
		rst <= 1'b0;
		@(negedge clk_sys);
		chk(new_c, exp_c, "reset coeff");
		chk(fs, 6'h18, "full swing");
		chk(lf, 6'h08, "low freq");
		chk(st, 3'd0, "idle");
		av(1'b0, 4'h0, 0);
		chk(q, 1, "ctrl reset");
		av(1'b0, 4'h8, 0);
		chk(q, exp_c, "coeff reg");
		// Every preset code, reserved ones keep the old setting
		for (int p = 0; p < 16; p++) begin
			if (p <= 10) begin
				act = 4'(p);
				exp_c = {6'(pre_tab[p]), 6'(24 - pre_tab[p] - post_tab[p]), 6'(post_tab[p])};
			end
			rq(2'h1, 4'(p), 18'($urandom), 1'b1);
			av(1'b0, 4'h4, 0);
			chk(q[7:4], act, "active preset");
			chk(q[2:0], 0, "status idle");
		end
		repeat (4) begin
			exp_c = 18'($urandom);
			rq(2'h2, 4'h0, exp_c, 1'b1);
		end
		av(1'b0, 4'h8, 0);
		chk(q, exp_c, "coeff reg");
		rq(2'h3, 4'h0, 18'($urandom), 1'b1);
		link_rate <= 2'h1;
		rq(2'h1, 4'h0, 18'h0_0000, 1'b0);
		link_rate <= 2'h2;
		// Enable write without its byte lane must be ignored
		avs_be <= 4'he;
		av(1'b1, 4'h0, 0);
		av(1'b0, 4'h0, 0);
		chk(q, 1, "ctrl byte lane");
		avs_be <= 4'hf;
		av(1'b1, 4'h0, 0);
		rq(2'h1, 4'h0, 18'h0_0000, 1'b0);
		av(1'b1, 4'h0, 1);
		av(1'b1, 4'hc, 32'hffff_ffff);
		av(1'b0, 4'hc, 0);
		chk(q, 0, "unmapped read");
		exp_c = 18'h0_0486;
		rq(2'h1, 4'h0, 18'h0_0000, 1'b1);
		final_report();
	end
endmodule : tb

`default_nettype wire
